// file: logic/srmf_mode_register_four.v
`timescale 1ns/1ps
`include "srmf_regs.vh"

module srmf_mode_register_four #(
    parameter HARD_REPAIR_SUPPORTED = 1'b1,
    parameter SOFT_REPAIR_SUPPORTED = 1'b1
) (
    input  wire                   ref_clk,
    input  wire                   reset_n,
    input  wire                   por_n,
    input  wire                   clk_en,
    input  wire                   cs_n,
    input  wire                   act_n,
    input  wire                   ras_n,
    input  wire                   cas_n,
    input  wire                   we_n,
    input  wire [1:0]             bg,
    input  wire [1:0]             ba,
    input  wire                   a17,
    input  wire [13:0]            addr,
    input  wire                   device_selected,
    input  wire                   gear_sync,
    input  wire                   power_down,
    input  wire                   max_power_exit,
    input  wire                   repair_req,
    input  wire [3:0]             repair_bank,
    input  wire [`SRMF_ROW_W-1:0] repair_row,
    output wire [`SRMF_W-1:0]     mode_register_four_config,
    output wire                   hard_row_repair,
    output wire                   write_preamble_length,
    output wire                   read_preamble_length,
    output wire                   read_preamble_training,
    output wire                   self_refresh_abort,
    output wire                   soft_row_repair,
    output wire                   vref_monitor,
    output wire                   temp_refresh_en,
    output wire                   temp_refresh_extended,
    output wire                   max_power_saving,
    output wire                   selftest_row_repair,
    output reg  [3:0]             cal_cycles,
    output reg                    cal_code_illegal,
    output reg                    reserved_written,
    output reg                    quarter_rate,
    output reg                    gear_wait_sync,
    output reg                    per_device_mode,
    output reg                    readback_mode,
    output reg  [7:0]             readback_data,
    output reg                    readback_valid,
    output reg                    repair_done,
    output reg                    repair_refused,
    output reg                    row_redirect,
    output reg                    row_redirect_soft
);

    localparam ST_HALF    = 2'h0;
    localparam ST_SYNC    = 2'h1;
    localparam ST_QUARTER = 2'h2;

    function [2:0] cmd_kind;
        input c_cs_n;
        input c_act_n;
        input c_ras_n;
        input c_cas_n;
        input c_we_n;
        begin
            if (c_cs_n)
                cmd_kind = `SRMF_CMD_NONE;
            else if (!c_act_n)
                cmd_kind = `SRMF_CMD_ACT;
            else if (!c_ras_n && !c_cas_n && !c_we_n)
                cmd_kind = `SRMF_CMD_MRS;
            else if (c_ras_n && !c_cas_n && c_we_n)
                cmd_kind = `SRMF_CMD_RD;
            else
                cmd_kind = `SRMF_CMD_NONE;
        end
    endfunction

    reg  [`SRMF_W-1:0]     cf4;
    reg  [4:0]             cf3;
    reg  [1:0]             gear_state;
    reg  [1:0]             next_gear_state;
    reg  [15:0]            hard_used;
    reg  [`SRMF_ROW_W-1:0] hard_row [0:`SRMF_BANKS-1];
    reg  [15:0]            soft_valid;
    reg  [`SRMF_ROW_W-1:0] soft_row [0:`SRMF_BANKS-1];
    integer                i;
    integer                j;

    wire [2:0]             kind;
    wire                   addressed;
    wire                   awake;
    wire                   mrs_ok;
    wire [2:0]             sel;
    wire [`SRMF_W-1:0]     capture;
    wire [3:0]             bank;
    wire [3:0]             dec_cycles;
    wire                   dec_reserved;
    wire                   dec_illegal;
    wire                   hard_hit;
    wire                   soft_hit;
    wire [7:0]             page_two_loc0;

    assign kind = cmd_kind(cs_n, act_n, ras_n, cas_n, we_n);
    // an unselected device still sees the bus but must not act on it
    assign addressed = !cf3[`SRMF_M3_PDA] || device_selected;
    // max power saving: commands and repair requests are ignored until the exit request or reset
    assign awake  = !cf4[`SRMF_B_MPS];
    assign mrs_ok = (kind == `SRMF_CMD_MRS) && addressed && awake;
    assign sel    = {bg[0], ba};
    // pins to register bits; 16:14 are command pins, held zero
    assign capture = {bg, ba, a17, 3'h0, addr};
    assign bank = {bg, ba};

    assign hard_hit = hard_used[bank] && (hard_row[bank] == addr);
    assign soft_hit = soft_valid[bank] && (soft_row[bank] == addr);

    assign page_two_loc0 = {HARD_REPAIR_SUPPORTED[0],
                            SOFT_REPAIR_SUPPORTED[0], 6'h00};

    srmf_cal_decode u_cal (
        .code     (capture[`SRMF_B_CAL_HI:`SRMF_B_CAL_LO]),
        .quarter  (quarter_rate),
        .cycles   (dec_cycles),
        .reserved (dec_reserved),
        .illegal  (dec_illegal)
    );

    // register four: loaded only by its own select code
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cf4              <= `SRMF_RESET_VAL;
            cal_cycles       <= 4'h0;
            cal_code_illegal <= 1'b0;
            reserved_written <= 1'b0;
        end else if (clk_en) begin
            if (mrs_ok && sel == `SRMF_SEL_FOUR) begin
                cf4        <= capture;
                cal_cycles <= dec_cycles;
                cal_code_illegal <= dec_illegal;
                // a one in bits 21 or 17 is kept but flagged
                reserved_written <= capture[`SRMF_B_RSV_HI] |
                                    capture[`SRMF_B_RSV_LO] |
                                    dec_reserved;
            end else if (cf4[`SRMF_B_MPS] && max_power_exit) begin
                cf4[`SRMF_B_MPS] <= 1'b0;
            end
        end
    end

    // register three: loaded by its own select code; a rate change does not re-check the stored latency code
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cf3 <= 5'h00;
        end else if (clk_en) begin
            if (mrs_ok && sel == `SRMF_SEL_THREE)
                cf3 <= capture[4:0];
        end
    end

    always @* begin
        next_gear_state = gear_state;
        case (gear_state)
            ST_HALF: begin
                if (mrs_ok && sel == `SRMF_SEL_THREE &&
                    capture[`SRMF_M3_GEAR])
                    next_gear_state = ST_SYNC;
            end
            ST_SYNC: begin
                if (mrs_ok && sel == `SRMF_SEL_THREE &&
                    !capture[`SRMF_M3_GEAR])
                    next_gear_state = ST_HALF;
                else if (gear_sync)
                    next_gear_state = ST_QUARTER;
            end
            ST_QUARTER: begin
                // back to half rate is immediate: no sync is required
                if (mrs_ok && sel == `SRMF_SEL_THREE &&
                    !capture[`SRMF_M3_GEAR])
                    next_gear_state = ST_HALF;
            end
            default: next_gear_state = ST_HALF;
        endcase
    end

    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            gear_state      <= ST_HALF;
            quarter_rate    <= 1'b0;
            gear_wait_sync  <= 1'b0;
            per_device_mode <= 1'b0;
            readback_mode   <= 1'b0;
        end else if (clk_en) begin
            gear_state      <= next_gear_state;
            quarter_rate    <= (next_gear_state == ST_QUARTER);
            gear_wait_sync  <= (next_gear_state == ST_SYNC);
            per_device_mode <= (mrs_ok && sel == `SRMF_SEL_THREE) ?
                               capture[`SRMF_M3_PDA] : per_device_mode;
            readback_mode   <= (mrs_ok && sel == `SRMF_SEL_THREE) ?
                               capture[`SRMF_M3_READBACK] :
                               readback_mode;
        end
    end

    // readback: reads return register data rather than array data
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            readback_data  <= 8'h00;
            readback_valid <= 1'b0;
        end else if (clk_en) begin
            readback_valid <= 1'b0;
            if (kind == `SRMF_CMD_RD && addressed && awake &&
                cf3[`SRMF_M3_READBACK]) begin
                readback_valid <= 1'b1;
                if (cf3[`SRMF_M3_PAGE_HI:`SRMF_M3_PAGE_LO] ==
                    `SRMF_PAGE_TWO && ba == `SRMF_LOC_ZERO)
                    readback_data <= page_two_loc0;
                else
                    readback_data <= 8'h00;
            end
        end
    end

    // fuse image: survives the command reset, cleared only at power-on
    always @(posedge ref_clk or negedge por_n) begin
        if (!por_n) begin
            hard_used <= 16'h0000;
            for (i = 0; i < `SRMF_BANKS; i = i + 1)
                hard_row[i] <= {`SRMF_ROW_W{1'b0}};
        end else if (clk_en) begin
            if (repair_req && awake && cf4[`SRMF_B_HARD] &&
                HARD_REPAIR_SUPPORTED[0] && !hard_used[repair_bank]) begin
                hard_used[repair_bank] <= 1'b1;
                hard_row[repair_bank]  <= repair_row;
            end
        end
    end

    // soft repair is volatile: lost on reset and on power-down
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            soft_valid <= 16'h0000;
            for (j = 0; j < `SRMF_BANKS; j = j + 1)
                soft_row[j] <= {`SRMF_ROW_W{1'b0}};
        end else if (clk_en) begin
            if (power_down) begin
                soft_valid <= 16'h0000;
            end else if (repair_req && awake && !cf4[`SRMF_B_HARD] &&
                         cf4[`SRMF_B_SOFT] && SOFT_REPAIR_SUPPORTED[0]) begin
                // a new address in the same bank replaces the old one
                soft_valid[repair_bank] <= 1'b1;
                soft_row[repair_bank]   <= repair_row;
            end
        end
    end

    // repair outcome pulses; hard mode wins when both are enabled
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            repair_done    <= 1'b0;
            repair_refused <= 1'b0;
        end else if (clk_en) begin
            repair_done    <= 1'b0;
            repair_refused <= 1'b0;
            if (repair_req) begin
                if (!awake) begin
                    repair_refused <= 1'b1;
                end else if (cf4[`SRMF_B_HARD]) begin
                    if (HARD_REPAIR_SUPPORTED[0] && !hard_used[repair_bank])
                        repair_done <= 1'b1;
                    else
                        repair_refused <= 1'b1;
                end else if (cf4[`SRMF_B_SOFT] &&
                             SOFT_REPAIR_SUPPORTED[0] && !power_down) begin
                    repair_done <= 1'b1;
                end else begin
                    repair_refused <= 1'b1;
                end
            end
        end
    end

    // activate to a repaired row is steered to the spare row
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            row_redirect      <= 1'b0;
            row_redirect_soft <= 1'b0;
        end else if (clk_en) begin
            row_redirect      <= 1'b0;
            row_redirect_soft <= 1'b0;
            if (kind == `SRMF_CMD_ACT && addressed && awake) begin
                if (hard_hit) begin
                    row_redirect <= 1'b1;
                end else if (soft_hit) begin
                    row_redirect      <= 1'b1;
                    row_redirect_soft <= 1'b1;
                end
            end
        end
    end

    assign mode_register_four_config = cf4;
    assign hard_row_repair        = cf4[`SRMF_B_HARD];
    assign write_preamble_length  = cf4[`SRMF_B_WPRE];
    assign read_preamble_length   = cf4[`SRMF_B_RPRE];
    assign read_preamble_training = cf4[`SRMF_B_RTRAIN];
    assign self_refresh_abort     = cf4[`SRMF_B_SRABORT];
    assign soft_row_repair        = cf4[`SRMF_B_SOFT];
    assign vref_monitor           = cf4[`SRMF_B_VREFMON];
    assign temp_refresh_en        = cf4[`SRMF_B_TCR_EN];
    assign temp_refresh_extended  = cf4[`SRMF_B_TCR_RANGE];
    assign max_power_saving       = cf4[`SRMF_B_MPS];
    assign selftest_row_repair    = cf4[`SRMF_B_SELFTEST];

endmodule

// file: include/srmf_regs.vh
// Contract
// - MRS with select bits 20:18 = 100 loads register four; 111 never used; t_reserved sends it once.
// - bits 21:18 from BG/BA, bit 17 from A17, 13:0 from A13..A0.
// - bit 13 enables hard row repair.
// - bit 12 picks write preamble: 0 one clock, 1 two clocks.
// - bit 11 picks read preamble: 0 one clock, 1 two clocks.
// - bit 10 enables read preamble training for strobe receiver leveling.
// - bit 9 enables self refresh abort.
// - bits 8:6 give latency 0,3,4,5,6,8 clocks; 110, 111 reserved.
// - bit 5 enables soft row repair.
// - bit 3 enables temperature refresh, bit 2 picks extended range.
// - bits 4, 1, 0 enable ref monitor, max power saving, self-test repair.
// - readback page 2 location 0 bit 7 shows hard repair support.
// - readback page 2 location 0 bit 6 shows soft repair support.
// - hard repair: one row per bank, permanent.
// - soft repair: one row per bank, undone by reset, power-down, rewrite.
// - starts half rate; quarter rate needs MRS then a sync pulse.
// - with per-device addressing on, only a selected device obeys commands.
// - register three bit 3 selects gear-down: 0 half, 1 quarter rate.
// - register three bit 2 enables readback; reads return register data.
`ifndef SRMF_REGS_VH
`define SRMF_REGS_VH

`define SRMF_W              22
`define SRMF_ROW_W          14
`define SRMF_BANKS          16
`define SRMF_SEL_HI         20
`define SRMF_SEL_LO         18
`define SRMF_SEL_THREE      3'h3
`define SRMF_SEL_FOUR       3'h4
`define SRMF_SEL_DO_NOT_USE 3'h7
`define SRMF_RESET_VAL      22'h000000

`define SRMF_B_RSV_HI       21
`define SRMF_B_RSV_LO       17
`define SRMF_B_HARD         13
`define SRMF_B_WPRE         12
`define SRMF_B_RPRE         11
`define SRMF_B_RTRAIN       10
`define SRMF_B_SRABORT      9
`define SRMF_B_CAL_HI       8
`define SRMF_B_CAL_LO       6
`define SRMF_B_SOFT         5
`define SRMF_B_VREFMON      4
`define SRMF_B_TCR_EN       3
`define SRMF_B_TCR_RANGE    2
`define SRMF_B_MPS          1
`define SRMF_B_SELFTEST     0

`define SRMF_M3_PDA         4
`define SRMF_M3_GEAR        3
`define SRMF_M3_READBACK    2
`define SRMF_M3_PAGE_HI     1
`define SRMF_M3_PAGE_LO     0
`define SRMF_PAGE_TWO       2'h2
`define SRMF_LOC_ZERO       2'h0
`define SRMF_RB_HARD        7
`define SRMF_RB_SOFT        6

`define SRMF_CAL_OFF        3'h0
`define SRMF_CAL_3          3'h1
`define SRMF_CAL_4          3'h2
`define SRMF_CAL_5          3'h3
`define SRMF_CAL_6          3'h4
`define SRMF_CAL_8          3'h5
`define SRMF_CAL_RSV6       3'h6
`define SRMF_CAL_RSV7       3'h7

`define SRMF_CMD_NONE       3'h0
`define SRMF_CMD_MRS        3'h1
`define SRMF_CMD_RD         3'h2
`define SRMF_CMD_ACT        3'h3

`endif

// file: logic/srmf_cal_decode.v
`timescale 1ns/1ps
`include "srmf_regs.vh"

module srmf_cal_decode (
    input  wire [2:0] code,
    input  wire       quarter,
    output reg  [3:0] cycles,
    output reg        reserved,
    output reg        illegal
);

    always @* begin
        cycles   = 4'h0;
        reserved = 1'b0;
        case (code)
            `SRMF_CAL_OFF: cycles = 4'h0;
            `SRMF_CAL_3:   cycles = 4'h3;
            `SRMF_CAL_4:   cycles = 4'h4;
            `SRMF_CAL_5:   cycles = 4'h5;
            `SRMF_CAL_6:   cycles = 4'h6;
            `SRMF_CAL_8:   cycles = 4'h8;
            default:       reserved = 1'b1;
        endcase
        // latencies 3 and 5 (codes 1 and 3) cannot align with the doubled command clock
        illegal = reserved | (quarter & ((code == `SRMF_CAL_3) |
                                         (code == `SRMF_CAL_5)));
    end

endmodule

// file: verif/srmf_ctrl_model.sv
`timescale 1ns/1ps
`include "srmf_regs.vh"

module srmf_ctrl_model (
    input  wire         ref_clk,
    output logic        cs_n,
    output logic        act_n,
    output logic        ras_n,
    output logic        cas_n,
    output logic        we_n,
    output logic [1:0]  bg,
    output logic [1:0]  ba,
    output logic        a17,
    output logic [13:0] addr
);
    initial begin
        {cs_n, act_n, ras_n, cas_n, we_n} = 5'h1F;
        {bg, ba, a17, addr} = 19'h0;
    end

    // no writes go out, so write latency never matters
    // one command, held across exactly one sampling edge
    task automatic issue(input [2:0] kind, input [1:0] g, input [1:0] b,
                         input a, input [13:0] ad);
        @(posedge ref_clk);
        cs_n <= 1'h0;
        act_n <= kind != `SRMF_CMD_ACT;
        ras_n <= kind == `SRMF_CMD_RD;
        cas_n <= 1'h0;
        we_n <= kind == `SRMF_CMD_RD;
        {bg, ba, a17, addr} <= {g, b, a, ad};
        @(posedge ref_clk);
        cs_n <= 1'h1;
        // released bus shows the inverse so a stale value never matches
        {bg, ba, a17, addr} <= ~{g, b, a, ad};
    endtask
endmodule

// file: verif/srmf_mode_register_four_chk.sv
`timescale 1ns/1ps

module srmf_mode_register_four_chk (
    input wire        ref_clk,
    input wire        reset_n,
    input wire        clk_en,
    input wire        cs_n,
    input wire        act_n,
    input wire        ras_n,
    input wire        cas_n,
    input wire        we_n,
    input wire [1:0]  bg,
    input wire [1:0]  ba,
    input wire        a17,
    input wire [13:0] addr,
    input wire        device_selected,
    input wire        gear_sync,
    input wire        max_power_exit,
    input wire        repair_req,
    input wire [21:0] mode_register_four_config,
    input wire        hard_row_repair,
    input wire        soft_row_repair,
    input wire        max_power_saving,
    input wire [3:0]  cal_cycles,
    input wire        cal_code_illegal,
    input wire        reserved_written,
    input wire        quarter_rate,
    input wire        gear_wait_sync,
    input wire        per_device_mode,
    input wire        readback_mode,
    input wire        readback_valid,
    input wire        repair_done,
    input wire        repair_refused,
    input wire        row_redirect,
    input wire        row_redirect_soft
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    wire ok = clk_en && !cs_n && !max_power_saving
              && (!per_device_mode || device_selected);
    wire mrs = ok && act_n && !ras_n && !cas_n && !we_n;
    wire take4 = mrs && {bg[0], ba} == 3'h4;
    wire rd = ok && act_n && ras_n && !cas_n && we_n;
    wire [21:0] cfg = mode_register_four_config;

    function automatic [3:0] lat(input [2:0] c);
        lat = (c == 3'h5) ? 4'h8 : (c == 3'h0) ? 4'h0 : {1'h0, c} + 4'h2;
    endfunction

    property p_load;
        take4 |=> cfg == {$past(bg), $past(ba), $past(a17), 3'h0, $past(addr)};
    endproperty
    a_load: assert property (p_load) else $error("config load wrong");
    property p_hold;
        !take4 && !max_power_exit |=> $stable(cfg);
    endproperty
    a_hold: assert property (p_hold) else $error("config changed");
    property p_map;
        hard_row_repair == cfg[13] && soft_row_repair == cfg[5]
        && max_power_saving == cfg[1];
    endproperty
    a_map: assert property (p_map) else $error("field map wrong");
    property p_cal;
        take4 && addr[8:6] < 3'h6 |=> cal_cycles == lat($past(addr[8:6]));
    endproperty
    a_cal: assert property (p_cal) else $error("latency wrong");
    property p_calq;
        take4 && quarter_rate && (addr[8:6] == 3'h1 || addr[8:6] == 3'h3)
        |=> cal_code_illegal;
    endproperty
    a_calq: assert property (p_calq) else $error("no illegal flag");
    property p_rsv;
        take4 && (bg[1] || a17) |=> reserved_written;
    endproperty
    a_rsv: assert property (p_rsv) else $error("no reserved flag");
    property p_gear;
        gear_wait_sync && gear_sync && clk_en
        |=> quarter_rate && !gear_wait_sync;
    endproperty
    a_gear: assert property (p_gear) else $error("sync ignored");
    property p_rb;
        rd && readback_mode |=> readback_valid;
    endproperty
    a_rb: assert property (p_rb) else $error("no readback");
    property p_rbv;
        readback_valid |-> $past(rd);
    endproperty
    a_rbv: assert property (p_rbv) else $error("stray readback");
    property p_pda;
        per_device_mode && !device_selected && !max_power_exit
        |=> $stable(cfg);
    endproperty
    a_pda: assert property (p_pda) else $error("unselected write");
    property p_rep;
        repair_req && clk_en |=> repair_done != repair_refused;
    endproperty
    a_rep: assert property (p_rep) else $error("repair no answer");
    property p_redir;
        row_redirect_soft |-> row_redirect;
    endproperty
    a_redir: assert property (p_redir) else $error("soft alone");

    c_take4: cover property (take4);
    c_quarter: cover property ($rose(quarter_rate));
    c_rb: cover property (readback_valid);
    c_rep: cover property (repair_done);
endmodule

bind srmf_mode_register_four srmf_mode_register_four_chk u_chk (.*);

// file: verif/srmf_mode_register_four_bench.sv
`timescale 1ns/1ps
`include "srmf_regs.vh"

module srmf_mode_register_four_bench;
    logic        ref_clk, reset_n, por_n, clk_en, device_selected, gear_sync;
    logic        power_down, max_power_exit, repair_req;
    logic [3:0]  repair_bank;
    logic [13:0] repair_row;
    wire         cs_n, act_n, ras_n, cas_n, we_n, a17;
    wire  [1:0]  bg, ba;
    wire  [13:0] addr;
    wire  [21:0] cfg;
    wire  [10:0] f;
    wire  [3:0]  cal;
    wire  [7:0]  rb_data;
    wire         cal_bad, rsv_wr, quarter, wait_sync, pda, rb_mode;
    wire         rb_valid, done, refused, redir, redir_soft;
    int          mismatches;
    int          num_checks;

    srmf_ctrl_model u_ctrl (.ref_clk, .cs_n, .act_n, .ras_n, .cas_n, .we_n,
        .bg, .ba, .a17, .addr);

    srmf_mode_register_four u_dut (.ref_clk, .reset_n, .por_n, .clk_en,
        .cs_n, .act_n, .ras_n, .cas_n, .we_n, .bg, .ba, .a17, .addr,
        .device_selected, .gear_sync, .power_down, .max_power_exit,
        .repair_req, .repair_bank, .repair_row,
        .mode_register_four_config(cfg), .hard_row_repair(f[10]),
        .write_preamble_length(f[9]), .read_preamble_length(f[8]),
        .read_preamble_training(f[7]), .self_refresh_abort(f[6]),
        .soft_row_repair(f[5]), .vref_monitor(f[4]),
        .temp_refresh_en(f[3]), .temp_refresh_extended(f[2]),
        .max_power_saving(f[1]), .selftest_row_repair(f[0]),
        .cal_cycles(cal), .cal_code_illegal(cal_bad),
        .reserved_written(rsv_wr), .quarter_rate(quarter),
        .gear_wait_sync(wait_sync), .per_device_mode(pda),
        .readback_mode(rb_mode), .readback_data(rb_data),
        .readback_valid(rb_valid), .repair_done(done),
        .repair_refused(refused), .row_redirect(redir),
        .row_redirect_soft(redir_soft));

    initial begin
        ref_clk = 1'h0;
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic chk(input string nm, input logic [21:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic mrs(input [2:0] sel, input [13:0] ad);
        u_ctrl.issue(`SRMF_CMD_MRS, {1'h0, sel[2]}, sel[1:0], 1'h0, ad);
        #1;
    endtask

    task automatic act(input [3:0] bank, input [13:0] row);
        u_ctrl.issue(`SRMF_CMD_ACT, bank[3:2], bank[1:0], 1'h0, row);
        #1;
    endtask

    task automatic rep(input [3:0] bank, input [13:0] row);
        @(posedge ref_clk);
        repair_req <= 1'h1;
        repair_bank <= bank;
        repair_row <= row;
        @(posedge ref_clk);
        repair_req <= 1'h0;
        #1;
    endtask

    task automatic t_fields;
        logic [13:0] ad;
        for (int c = 0; c < 8; c++) begin
            ad = (c[0] ? 14'h3E3D : 14'h1C15) | 14'(c << 6);
            mrs(3'h4, ad);
            chk("cfg", cfg, {8'h40, ad});
            chk("fields", f, {ad[13:9], ad[5:0]});
            chk("cal_bad", cal_bad, c > 5);
            chk("rsv_wr", rsv_wr, c > 5);
            if (c < 6) begin
                chk("cal", cal, c == 5 ? 8 : c == 0 ? 0 : c + 2);
            end
        end
    endtask

    task automatic t_reserved;
        u_ctrl.issue(`SRMF_CMD_MRS, 2'h3, 2'h0, 1'h1, 14'h0000);
        #1;
        chk("rsv_cfg", cfg, 22'h320000);
        chk("rsv_flag", rsv_wr, 1'h1);
        mrs(3'h7, 14'h3FFD);
        mrs(3'h5, 14'h1000);
        chk("sel_other", cfg, 22'h320000);
    endtask

    task automatic t_gear;
        mrs(3'h3, 14'h0008);
        chk("wait", wait_sync, 1'h1);
        chk("q_early", quarter, 1'h0);
        @(posedge ref_clk);
        gear_sync <= 1'h1;
        @(posedge ref_clk);
        gear_sync <= 1'h0;
        #1;
        chk("quarter", quarter, 1'h1);
        mrs(3'h4, 14'h0040);
        chk("cal3_q", cal_bad, 1'h1);
        mrs(3'h4, 14'h0080);
        chk("cal4_q", cal_bad, 1'h0);
        mrs(3'h3, 14'h0000);
        chk("half", quarter, 1'h0);
    endtask

    task automatic t_readback;
        mrs(3'h3, 14'h0006);
        chk("rb_mode", rb_mode, 1'h1);
        u_ctrl.issue(`SRMF_CMD_RD, 2'h0, 2'h0, 1'h0, 14'h0000);
        #1;
        chk("rb_valid", rb_valid, 1'h1);
        chk("rb_data", rb_data, 8'hC0);
        @(posedge ref_clk);
        #1;
        chk("rb_pulse", rb_valid, 1'h0);
        mrs(3'h3, 14'h0000);
    endtask

    task automatic t_pda;
        mrs(3'h4, 14'h0000);
        mrs(3'h3, 14'h0010);
        chk("pda", pda, 1'h1);
        @(posedge ref_clk);
        device_selected <= 1'h0;
        mrs(3'h4, 14'h0200);
        chk("pda_off", cfg, 22'h100000);
        @(posedge ref_clk);
        device_selected <= 1'h1;
        mrs(3'h4, 14'h0200);
        chk("pda_on", cfg, 22'h100200);
        mrs(3'h3, 14'h0000);
    endtask

    task automatic t_mps;
        mrs(3'h4, 14'h0002);
        chk("mps", f[1], 1'h1);
        mrs(3'h4, 14'h0000);
        chk("mps_deaf", cfg, 22'h100002);
        @(posedge ref_clk);
        max_power_exit <= 1'h1;
        @(posedge ref_clk);
        max_power_exit <= 1'h0;
        #1;
        chk("mps_exit", f[1], 1'h0);
        @(posedge ref_clk);
        clk_en <= 1'h0;
        mrs(3'h4, 14'h0200);
        chk("frozen", cfg, 22'h100000);
        @(posedge ref_clk);
        clk_en <= 1'h1;
    endtask

    task automatic t_repair;
        mrs(3'h4, 14'h2000);
        rep(4'h3, 14'h0005);
        chk("hard_done", done, 1'h1);
        rep(4'h3, 14'h0009);
        chk("hard_twice", refused, 1'h1);
        act(4'h3, 14'h0005);
        chk("hard_hit", {redir, redir_soft}, 2'h2);
        mrs(3'h4, 14'h0020);
        rep(4'h4, 14'h0007);
        chk("soft_done", done, 1'h1);
        act(4'h4, 14'h0007);
        chk("soft_hit", {redir, redir_soft}, 2'h3);
        rep(4'h4, 14'h0008);
        act(4'h4, 14'h0007);
        chk("soft_old", redir, 1'h0);
        act(4'h4, 14'h0008);
        chk("soft_new", redir_soft, 1'h1);
        @(posedge ref_clk);
        power_down <= 1'h1;
        @(posedge ref_clk);
        power_down <= 1'h0;
        act(4'h4, 14'h0008);
        chk("soft_pd", redir, 1'h0);
        @(posedge ref_clk);
        reset_n <= 1'h0;
        @(posedge ref_clk);
        reset_n <= 1'h1;
        @(posedge ref_clk);
        #1;
        chk("cfg_rst", cfg, 22'h0);
        act(4'h3, 14'h0005);
        chk("hard_keep", redir, 1'h1);
    endtask

    initial begin
        mismatches = 0;
        num_checks = 0;
        {reset_n, por_n, gear_sync, power_down, max_power_exit} = 5'h0;
        {clk_en, device_selected, repair_req} = 3'h6;
        repair_bank = 4'h0;
        repair_row = 14'h0000;
        repeat (10) @(posedge ref_clk);
        reset_n <= 1'h1;
        por_n <= 1'h1;
        @(posedge ref_clk);
        #1;
        chk("cfg_reset", cfg, 22'h0);
        t_fields;
        t_reserved;
        t_gear;
        t_readback;
        t_pda;
        t_mps;
        t_repair;
        stop_test;
    end

    // the whole run needs about a hundred cycles
    initial begin
        repeat (5000) @(posedge ref_clk);
        mismatches++;
        stop_test;
    end
endmodule
